// [hdl/scmcc_top.sv]
`timescale 1ns/10ps
// Function
// RL1 - system clock picks one of four sources
// RL2 - source codes: rc, hs, divided hs, 32M
// RL3 - divided source is hs over divider field
// RL4 - software keeps the divider two or more
// RL5 - hs code from two select bits
// RL6 - hs codes: doubled, rc, crystal
// RL7 - 32M is doubled clock times two thirds
// RL8 - three gate registers, bit per module
// RL9 - gate bit one passes, zero stops
// RL10 - timer gets crystal times two thirds
// RL11 - usb clock from the doubled clock
// RL12 - i2s clock runs only when enabled
// RL13 - i2s step and mod fields
// RL14 - i2s clock is 48M times step/mod
// RL15 - microphone clock runs only when enabled
// RL16 - microphone source: divider or 32 kHz
// RL17 - microphone step/mod fractional divider
// RL18 - 32 kHz source select bit
// RL19 - zero rc, one crystal for 32 kHz
// RL20 - switching never cuts a clock pulse
// every clock is carried as a one-cycle tick per source edge on aclk
module scmcc_top #(
  parameter int ADDR_W = 12 // axi address width
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // clock source ticks
  input wire logic rc_oscillator_fast_tick,
  input wire logic crystal_clock_fast_tick,
  input wire logic doubled_fast_tick,
  input wire logic rc_oscillator_slow_tick,
  input wire logic crystal_clock_slow_tick,
  // generated clock ticks
  output logic system_clock_tick,
  output logic timer_clock_tick,
  output logic usb_clock_tick,
  output logic i2s_clock_tick,
  output logic digital_microphone_tick,
  output logic slow_clock_tick,
  output logic [23:0] module_clock_tick,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // =====================================================================
  // functions
  // fractional step: returns {tick, next accumulator}
  function automatic logic [8:0] frac_step(input logic [7:0] acc, input logic [6:0] step,
                                            input logic [7:0] modv);
    logic [8:0] sum;
    sum = {1'b0, acc} + {2'b00, step};
    if (sum >= {1'b0, modv}) begin
      frac_step = {1'b1, 8'(sum - {1'b0, modv})};
    end else begin
      frac_step = {1'b0, sum[7:0]};
    end
  endfunction

  // two out of three phases pass a tick
  function automatic logic two_thirds_pass(input logic [1:0] ph);
    two_thirds_pass = (ph != scmcc_pkg::TWO_THIRDS_SKIP);
  endfunction

  function automatic logic [1:0] two_thirds_next(input logic [1:0] ph);
    two_thirds_next = (ph == scmcc_pkg::TWO_THIRDS_SKIP) ? 2'h0 : 2'(ph + 2'h1);
  endfunction

  // register map check
  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = idx inside {scmcc_pkg::IDX_GATE0, scmcc_pkg::IDX_GATE1,
                             scmcc_pkg::IDX_GATE2, scmcc_pkg::IDX_SYSSEL,
                             scmcc_pkg::IDX_I2S_STEP, scmcc_pkg::IDX_I2S_MOD,
                             scmcc_pkg::IDX_MIC_STEP, scmcc_pkg::IDX_MIC_MOD,
                             scmcc_pkg::IDX_HS_SEL, scmcc_pkg::IDX_LS_SEL,
                             scmcc_pkg::IDX_STATUS};
  endfunction

  // =====================================================================
  // declarations
  logic [7:0] gate_r [3]; // module gate registers
  logic [7:0] sysclk_sel_r; // system_clock_select
  logic [7:0] i2s_step_r; // i2s enable and step
  logic [7:0] i2s_mod_r; // i2s mod
  logic [7:0] mic_step_r; // microphone enable and step
  logic [7:0] mic_mod_r; // microphone mod
  logic [7:0] hs_sel_r; // high-speed select
  logic [7:0] ls_sel_r; // low-speed select
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_got_r, w_got_r; // write halves held
  logic [7:0] aw_idx_r; // held write index
  logic [7:0] w_byte_r; // held write byte
  logic w_lane_r; // byte lane 0 strobed
  logic wr_fire; // write performed this cycle
  logic [7:0] ar_idx; // read index
  logic [7:0] status_byte; // applied selections
  scmcc_pkg::scmcc_sys_src_type sys_act_r; // applied system source
  logic [1:0] hs_act_r; // applied high-speed code
  logic slow_act_r; // applied 32 kHz source
  logic mic_src_act_r; // applied microphone source
  logic [1:0] sys_req; // requested system source
  logic [1:0] hs_req; // requested high-speed code
  logic hs_tick; // selected high-speed tick
  logic [4:0] div_cnt_r; // high-speed divider count
  logic div_tick; // divided high-speed tick
  logic [1:0] ph32_r; // 32M two-thirds phase
  logic tick32; // 32M tick
  logic [1:0] ph_tmr_r; // timer two-thirds phase
  logic sys_tick; // selected system tick
  logic any_fast; // a fast source ticks now
  logic [7:0] i2s_acc_r, mic_acc_r; // fractional accumulators
  logic [8:0] i2s_frac, mic_frac; // step results
  logic slow_tick; // selected 32 kHz tick
  logic sys_tick_r, tmr_tick_r, usb_tick_r, i2s_tick_r, mic_tick_r, slow_tick_r;
  logic [23:0] mod_tick_r;

  // =====================================================================
  // axi write channels: address and data taken in either order
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_idx_r <= 8'h00;
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= scmcc_pkg::RESP_OKAY;
    end else if (ce) begin
      // address half
      if (awvalid && awready_r) begin
        aw_idx_r <= awaddr[9:2];
        aw_got_r <= 1'b1;
        awready_r <= 1'b0;
      end else if (!aw_got_r && !bvalid_r && !wr_fire) begin
        awready_r <= 1'b1;
      end
      // data half
      if (wvalid && wready_r) begin
        w_byte_r <= wdata[7:0];
        w_lane_r <= wstrb[0];
        w_got_r <= 1'b1;
        wready_r <= 1'b0;
      end else if (!w_got_r && !bvalid_r && !wr_fire) begin
        wready_r <= 1'b1;
      end
      // response after both halves
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (idx_mapped(aw_idx_r) && aw_idx_r != scmcc_pkg::IDX_STATUS) ?
                   scmcc_pkg::RESP_OKAY : scmcc_pkg::RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // =====================================================================
  // register writes, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_r[0] <= scmcc_pkg::RST_GATE0;
      gate_r[1] <= scmcc_pkg::RST_GATE1;
      gate_r[2] <= scmcc_pkg::RST_GATE2;
      sysclk_sel_r <= scmcc_pkg::RST_SYSSEL;
      i2s_step_r <= scmcc_pkg::RST_I2S_STEP;
      i2s_mod_r <= scmcc_pkg::RST_I2S_MOD;
      mic_step_r <= scmcc_pkg::RST_MIC_STEP;
      mic_mod_r <= scmcc_pkg::RST_MIC_MOD;
      hs_sel_r <= scmcc_pkg::RST_HS_SEL;
      ls_sel_r <= scmcc_pkg::RST_LS_SEL;
    end else if (ce && wr_fire && w_lane_r) begin
      unique case (aw_idx_r)
        scmcc_pkg::IDX_GATE0: gate_r[0] <= w_byte_r; // [RL8]
        scmcc_pkg::IDX_GATE1: gate_r[1] <= w_byte_r; // [RL8]
        scmcc_pkg::IDX_GATE2: gate_r[2] <= w_byte_r; // [RL8]
        scmcc_pkg::IDX_SYSSEL: sysclk_sel_r <= w_byte_r;
        scmcc_pkg::IDX_I2S_STEP: i2s_step_r <= w_byte_r; // [RL13]
        scmcc_pkg::IDX_I2S_MOD: i2s_mod_r <= w_byte_r; // [RL13]
        scmcc_pkg::IDX_MIC_STEP: mic_step_r <= w_byte_r; // [RL17]
        scmcc_pkg::IDX_MIC_MOD: mic_mod_r <= w_byte_r; // [RL17]
        scmcc_pkg::IDX_HS_SEL: hs_sel_r <= w_byte_r;
        scmcc_pkg::IDX_LS_SEL: ls_sel_r <= w_byte_r;
        default: ; // status and unmapped are not written
      endcase
    end
  end

  // =====================================================================
  // axi read channel
  assign ar_idx = araddr[9:2];
  assign status_byte = {2'b00, mic_src_act_r, slow_act_r, hs_act_r, sys_act_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= scmcc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rresp_r <= idx_mapped(ar_idx) ? scmcc_pkg::RESP_OKAY : scmcc_pkg::RESP_SLVERR;
        unique case (ar_idx)
          scmcc_pkg::IDX_GATE0: rdata_r <= {24'h000000, gate_r[0]};
          scmcc_pkg::IDX_GATE1: rdata_r <= {24'h000000, gate_r[1]};
          scmcc_pkg::IDX_GATE2: rdata_r <= {24'h000000, gate_r[2]};
          scmcc_pkg::IDX_SYSSEL: rdata_r <= {24'h000000, sysclk_sel_r};
          scmcc_pkg::IDX_I2S_STEP: rdata_r <= {24'h000000, i2s_step_r};
          scmcc_pkg::IDX_I2S_MOD: rdata_r <= {24'h000000, i2s_mod_r};
          scmcc_pkg::IDX_MIC_STEP: rdata_r <= {24'h000000, mic_step_r};
          scmcc_pkg::IDX_MIC_MOD: rdata_r <= {24'h000000, mic_mod_r};
          scmcc_pkg::IDX_HS_SEL: rdata_r <= {24'h000000, hs_sel_r};
          scmcc_pkg::IDX_LS_SEL: rdata_r <= {24'h000000, ls_sel_r};
          scmcc_pkg::IDX_STATUS: rdata_r <= {24'h000000, status_byte};
          default: rdata_r <= 32'h0000_0000; // unmapped reads zero
        endcase
      end else if (rvalid_r) begin
        if (rready) begin
          rvalid_r <= 1'b0;
        end
      end else begin
        arready_r <= 1'b1;
      end
    end
  end

  // =====================================================================
  // source selection, applied only between pulses
  assign sys_req = sysclk_sel_r[scmcc_pkg::SYS_SRC_LSB +: 2]; // [RL1]
  assign hs_req = {hs_sel_r[scmcc_pkg::HS_SEL_BIT], sysclk_sel_r[scmcc_pkg::SYS_HS_BIT]}; // [RL5]
  assign any_fast = rc_oscillator_fast_tick | crystal_clock_fast_tick | doubled_fast_tick;

  // each select moves only in a cycle where none of its own sources ticks, so no pulse is cut
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_act_r <= scmcc_pkg::SCMCC_SYS_RC;
      hs_act_r <= scmcc_pkg::HS_DOUBLED;
      slow_act_r <= 1'b0;
      mic_src_act_r <= 1'b0;
    end else if (ce) begin
      if (!any_fast) begin
        sys_act_r <= scmcc_pkg::scmcc_sys_src_type'(sys_req); // [RL20]
        hs_act_r <= hs_req; // [RL20]
      end
      if (!rc_oscillator_slow_tick && !crystal_clock_slow_tick) begin
        slow_act_r <= ls_sel_r[scmcc_pkg::LS_SLOW_BIT]; // [RL18] [RL20]
      end
      if (!doubled_fast_tick && !slow_tick) begin
        mic_src_act_r <= ls_sel_r[scmcc_pkg::LS_MIC_BIT]; // [RL16] [RL20]
      end
    end
  end

  // high-speed clock mux
  always_comb begin
    if (hs_act_r[1]) begin
      hs_tick = crystal_clock_fast_tick; // [RL6]
    end else if (hs_act_r == scmcc_pkg::HS_RC) begin
      hs_tick = rc_oscillator_fast_tick; // [RL6]
    end else begin
      hs_tick = doubled_fast_tick; // [RL6]
    end
  end

  // =====================================================================
  // high-speed divider: one tick per divider-field high-speed ticks
  assign div_tick = hs_tick && ({1'b0, div_cnt_r} + 6'h01 >=
                                {1'b0, sysclk_sel_r[scmcc_pkg::SYS_DIV_MSB:0]}); // [RL3]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= 5'h00;
    end else if (ce && hs_tick) begin
      div_cnt_r <= div_tick ? 5'h00 : 5'(div_cnt_r + 5'h01); // [RL3]
    end
  end

  // two-thirds dividers for 32M and the timer
  assign tick32 = doubled_fast_tick && two_thirds_pass(ph32_r); // [RL7]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph32_r <= 2'h0;
      ph_tmr_r <= 2'h0;
    end else if (ce) begin
      if (doubled_fast_tick) begin
        ph32_r <= two_thirds_next(ph32_r); // [RL7]
      end
      if (crystal_clock_fast_tick) begin
        ph_tmr_r <= two_thirds_next(ph_tmr_r); // [RL10]
      end
    end
  end

  // system clock mux
  always_comb begin
    unique case (sys_act_r)
      scmcc_pkg::SCMCC_SYS_RC: sys_tick = rc_oscillator_fast_tick; // [RL2]
      scmcc_pkg::SCMCC_SYS_HS: sys_tick = hs_tick; // [RL2]
      scmcc_pkg::SCMCC_SYS_DIV: sys_tick = div_tick; // [RL2]
      scmcc_pkg::SCMCC_SYS_32M: sys_tick = tick32; // [RL2]
    endcase
  end

  // =====================================================================
  // fractional dividers on the doubled clock
  assign i2s_frac = frac_step(i2s_acc_r, i2s_step_r[scmcc_pkg::STEP_MSB:0], i2s_mod_r);
  assign mic_frac = frac_step(mic_acc_r, mic_step_r[scmcc_pkg::STEP_MSB:0], mic_mod_r);
  assign slow_tick = slow_act_r ? crystal_clock_slow_tick : rc_oscillator_slow_tick; // [RL19]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      i2s_acc_r <= 8'h00;
      mic_acc_r <= 8'h00;
    end else if (ce && doubled_fast_tick) begin
      i2s_acc_r <= i2s_step_r[scmcc_pkg::STEP_EN_BIT] ? i2s_frac[7:0] : 8'h00; // [RL14]
      mic_acc_r <= mic_step_r[scmcc_pkg::STEP_EN_BIT] ? mic_frac[7:0] : 8'h00; // [RL17]
    end
  end

  // =====================================================================
  // output tick registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_tick_r <= 1'b0;
      tmr_tick_r <= 1'b0;
      usb_tick_r <= 1'b0;
      i2s_tick_r <= 1'b0;
      mic_tick_r <= 1'b0;
      slow_tick_r <= 1'b0;
      mod_tick_r <= 24'h000000;
    end else if (ce) begin
      sys_tick_r <= sys_tick;
      tmr_tick_r <= crystal_clock_fast_tick && two_thirds_pass(ph_tmr_r); // [RL10]
      usb_tick_r <= doubled_fast_tick; // [RL11]
      i2s_tick_r <= doubled_fast_tick && i2s_step_r[scmcc_pkg::STEP_EN_BIT]
                    && i2s_frac[8]; // [RL12] [RL14]
      if (mic_src_act_r) begin
        mic_tick_r <= mic_step_r[scmcc_pkg::STEP_EN_BIT] && slow_tick; // [RL15] [RL16]
      end else begin
        mic_tick_r <= mic_step_r[scmcc_pkg::STEP_EN_BIT] && doubled_fast_tick
                      && mic_frac[8]; // [RL15] [RL17]
      end
      slow_tick_r <= slow_tick;
      mod_tick_r <= {gate_r[2], gate_r[1], gate_r[0]} & {24{sys_tick}}; // [RL9]
    end
  end

  assign system_clock_tick = sys_tick_r;
  assign timer_clock_tick = tmr_tick_r;
  assign usb_clock_tick = usb_tick_r;
  assign i2s_clock_tick = i2s_tick_r;
  assign digital_microphone_tick = mic_tick_r;
  assign slow_clock_tick = slow_tick_r;
  assign module_clock_tick = mod_tick_r;
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // =====================================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  // helper: whether the last high-speed tick was also a divided tick
  logic div_last_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_last_r <= 1'b0;
    end else if (ce && hs_tick) begin
      div_last_r <= div_tick;
    end
  end

  // one doubled tick followed by a quiet cycle
  sequence dbl_pulse_s;
    doubled_fast_tick ##1 !doubled_fast_tick;
  endsequence

  sys_rc_route_a: assert property ( // [RL2]
    (sys_act_r == scmcc_pkg::SCMCC_SYS_RC) |=> (system_clock_tick == $past(rc_oscillator_fast_tick)))
    else $error("system tick does not follow rc source");
  hs_xtal_route_a: assert property ( // [RL6]
    (sys_act_r == scmcc_pkg::SCMCC_SYS_HS && hs_act_r[1])
    |=> (system_clock_tick == $past(crystal_clock_fast_tick)))
    else $error("high-speed crystal route wrong");
  div_spacing_a: assert property ( // [RL3]
    (hs_tick && div_last_r && sysclk_sel_r[4:0] == 5'h02) |-> !div_tick)
    else $error("divide by two ticked on adjacent high-speed ticks");
  thirty_two_a: assert property ( // [RL7]
    (sys_act_r == scmcc_pkg::SCMCC_SYS_32M && doubled_fast_tick && ph32_r == 2'h2)
    |=> !system_clock_tick)
    else $error("32M divider did not drop third tick");
  gate_bit_a: assert property ( // [RL9]
    sys_tick |=> (module_clock_tick[17] == $past(gate_r[2][1])))
    else $error("module clock does not follow its gate bit");
  i2s_off_a: assert property ( // [RL12]
    !i2s_step_r[7] |=> !i2s_clock_tick)
    else $error("i2s tick while disabled");
  mic_off_a: assert property ( // [RL15]
    !mic_step_r[7] |=> !digital_microphone_tick)
    else $error("microphone tick while disabled");
  usb_route_a: assert property ( // [RL11]
    dbl_pulse_s |=> !usb_clock_tick && $past(usb_clock_tick))
    else $error("usb tick does not follow doubled clock");
  slow_sel_a: assert property ( // [RL19]
    (slow_act_r && !rc_oscillator_slow_tick && crystal_clock_slow_tick) |=> slow_clock_tick)
    else $error("32 kHz crystal not routed");
  switch_quiet_a: assert property ( // [RL20]
    (sys_act_r != $past(sys_act_r)) |-> !$past(any_fast))
    else $error("system source switched during a pulse");
  timer_third_a: assert property ( // [RL10]
    (crystal_clock_fast_tick && ph_tmr_r == 2'h2) |=> !timer_clock_tick)
    else $error("timer divider passed the third tick");

endmodule

// [hdl/scmcc_pkg.sv]
// =====================================================================
// shared constants of the system and module clock control block
package scmcc_pkg;

  // =====================================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_GATE0 = 8'h63; // module_clock_gate_0
  localparam logic [7:0] IDX_GATE1 = 8'h64; // module_clock_gate_1
  localparam logic [7:0] IDX_GATE2 = 8'h65; // module_clock_gate_2
  localparam logic [7:0] IDX_SYSSEL = 8'h66; // system_clock_select
  localparam logic [7:0] IDX_I2S_STEP = 8'h67; // i2s_enable_and_step
  localparam logic [7:0] IDX_I2S_MOD = 8'h68; // i2s_divider_mod
  localparam logic [7:0] IDX_MIC_STEP = 8'h6C; // mic_enable_and_step
  localparam logic [7:0] IDX_MIC_MOD = 8'h6D; // mic_divider_mod
  localparam logic [7:0] IDX_HS_SEL = 8'h70; // high_speed_source_select
  localparam logic [7:0] IDX_LS_SEL = 8'h73; // low_speed_source_select
  localparam logic [7:0] IDX_STATUS = 8'h74; // applied selections, read only

  // =====================================================================
  // reset values
  localparam logic [7:0] RST_GATE0 = 8'h83;
  localparam logic [7:0] RST_GATE1 = 8'h00;
  localparam logic [7:0] RST_GATE2 = 8'h30;
  localparam logic [7:0] RST_SYSSEL = 8'h06;
  localparam logic [7:0] RST_I2S_STEP = 8'h00;
  localparam logic [7:0] RST_I2S_MOD = 8'h02;
  localparam logic [7:0] RST_MIC_STEP = 8'h01;
  localparam logic [7:0] RST_MIC_MOD = 8'h02;
  localparam logic [7:0] RST_HS_SEL = 8'h00;
  localparam logic [7:0] RST_LS_SEL = 8'h04;

  // =====================================================================
  // field positions
  localparam int SYS_DIV_MSB = 4; // divider field [4:0]
  localparam int SYS_SRC_LSB = 5; // source field [6:5]
  localparam int SYS_HS_BIT = 7; // low bit of high-speed code
  localparam int HS_SEL_BIT = 0; // high bit of high-speed code
  localparam int STEP_EN_BIT = 7; // divider enable
  localparam int STEP_MSB = 6; // step field [6:0]
  localparam int LS_SLOW_BIT = 0; // 32 kHz source
  localparam int LS_MIC_BIT = 1; // microphone source

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // =====================================================================
  // source encodings
  typedef enum logic [1:0] {
    SCMCC_SYS_RC = 2'h0,
    SCMCC_SYS_HS = 2'h1,
    SCMCC_SYS_DIV = 2'h2,
    SCMCC_SYS_32M = 2'h3
  } scmcc_sys_src_type;

  localparam logic [1:0] HS_DOUBLED = 2'h0; // 48 MHz doubled crystal
  localparam logic [1:0] HS_RC = 2'h1; // fast rc oscillator
  localparam logic [1:0] TWO_THIRDS_SKIP = 2'h2; // phase that drops a tick

endpackage

// [testbench/test_system_and_module_clock_control.sv]
`timescale 1ns/10ps
// ==========
// bench for the clock control block
module test_system_and_module_clock_control;
  logic aclk = 1'b0; // bus clock
  logic aresetn = 1'b0; // reset, low active
  logic [4:0] src = 5'h00; // ticks: rc fast, xtal fast, doubled, rc slow, xtal slow
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [5:0] outs; // sys, timer, usb, i2s, mic, slow
  logic [23:0] mct; // gated module ticks
  logic [23:0] mct_last; // module ticks seen with last system tick
  int cnt[6]; // output tick counts of one burst
  int mismatches = 0;
  int checked = 0;
  // ==========
  // device under test
  scmcc_top uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .rc_oscillator_fast_tick(src[0]), .crystal_clock_fast_tick(src[1]),
    .doubled_fast_tick(src[2]), .rc_oscillator_slow_tick(src[3]),
    .crystal_clock_slow_tick(src[4]), .system_clock_tick(outs[0]),
    .timer_clock_tick(outs[1]), .usb_clock_tick(outs[2]), .i2s_clock_tick(outs[3]),
    .digital_microphone_tick(outs[4]), .slow_clock_tick(outs[5]),
    .module_clock_tick(mct), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // ==========
  // clock and tick counting
  initial begin
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    for (int i = 0; i < 6; i++) begin
      if (outs[i] === 1'b1) cnt[i]++;
    end
    if (outs[0] === 1'b1) mct_last = mct;
  end
  // ==========
  // helpers
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  // one axi write, response compared
  task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {2'b00, ix, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({62'h0, bresp}, {62'h0, er});
  endtask
  // one axi read, data and response compared
  task automatic rd(input logic [7:0] ix, input logic [7:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {2'b00, ix, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk({rdata, 30'h0, rresp}, {24'h0, ed, 30'h0, er});
  endtask
  // n ticks of one source, gaps keep selects free to switch
  task automatic bx(input int s, input int n);
    @(posedge aclk);
    cnt = '{default: 0};
    repeat (n) begin
      src[s] <= 1'b1;
      @(posedge aclk);
      src[s] <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    repeat (2) @(posedge aclk);
  endtask
  // ==========
  // scenarios
  task automatic t_reg;
    logic [7:0] ix[10] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h6C, 8'h6D, 8'h70, 8'h73};
    logic [7:0] rv[10] = '{8'h83, 8'h00, 8'h30, 8'h06, 8'h00, 8'h02, 8'h01, 8'h02, 8'h00, 8'h04};
    for (int i = 0; i < 10; i++) rd(ix[i], rv[i], 2'h0);
    rd(8'h74, 8'h00, 2'h0);
    wr(8'h64, 8'hA5, 2'h0);
    rd(8'h64, 8'hA5, 2'h0);
    wstrb <= 4'hE;
    wr(8'h64, 8'h11, 2'h0);
    wstrb <= 4'hF;
    rd(8'h64, 8'hA5, 2'h0);
    wr(8'h10, 8'hFF, 2'h2);
    rd(8'h10, 8'h00, 2'h2);
    wr(8'h74, 8'hFF, 2'h2);
  endtask
  // divider field always two or more, even when not selected
  task automatic t_sys;
    bx(0, 4);
    chk(cnt[0], 4);
    bx(1, 6);
    chk(cnt[1], 4);
    bx(2, 6);
    chk(cnt[2], 6);
    chk(cnt[0], 0);
    wr(8'h66, 8'h22, 2'h0);
    bx(2, 4);
    chk(cnt[0], 4);
    wr(8'h66, 8'h62, 2'h0);
    bx(2, 6);
    chk(cnt[0], 4);
    wr(8'h66, 8'h43, 2'h0);
    bx(2, 6);
    chk(cnt[0], 2);
    wr(8'h66, 8'h42, 2'h0);
    bx(2, 6);
    chk(cnt[0], 3);
    wr(8'h66, 8'hA2, 2'h0);
    bx(0, 3);
    chk(cnt[0], 3);
    wr(8'h70, 8'h01, 2'h0);
    wr(8'h66, 8'h22, 2'h0);
    bx(1, 3);
    chk(cnt[0], 3);
  endtask
  task automatic t_gate;
    wr(8'h63, 8'h81, 2'h0);
    wr(8'h64, 8'h3C, 2'h0);
    wr(8'h65, 8'h5A, 2'h0);
    bx(1, 2);
    chk(mct_last, 24'h5A3C81);
    wr(8'h65, 8'h00, 2'h0);
    bx(1, 2);
    chk(mct_last, 24'h003C81);
  endtask
  // mod raised before step, so mod never drops below twice step
  task automatic t_frac;
    bx(2, 4);
    chk(cnt[3], 0);
    chk(cnt[4], 0);
    wr(8'h67, 8'h81, 2'h0);
    wr(8'h68, 8'h02, 2'h0);
    bx(2, 8);
    chk(cnt[3], 4);
    wr(8'h68, 8'h08, 2'h0);
    wr(8'h67, 8'h83, 2'h0);
    wr(8'h6C, 8'h81, 2'h0);
    wr(8'h6D, 8'h04, 2'h0);
    bx(2, 16);
    chk(cnt[3], 6);
    chk(cnt[4], 4);
    wr(8'h67, 8'h03, 2'h0);
    bx(2, 4);
    chk(cnt[3], 0);
  endtask
  task automatic t_slow;
    wr(8'h73, 8'h06, 2'h0);
    bx(3, 3);
    chk(cnt[4], 3);
    chk(cnt[5], 3);
    bx(4, 3);
    chk(cnt[5], 0);
    wr(8'h73, 8'h07, 2'h0);
    bx(4, 3);
    chk(cnt[5], 3);
    bx(2, 4);
    chk(cnt[4], 0);
  endtask
  // ==========
  // watchdog and main sequence
  initial begin
    #(100 * 30000);
    mismatches++;
    $display("MISMATCH %0t watchdog ran out", $time);
    conclude();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reg();
    t_sys();
    t_gate();
    t_frac();
    t_slow();
    conclude();
  end
endmodule
